// ===== design/mcrc_pkg.sv
package mcrc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned POR_MAX_US       = 1000;
  localparam int unsigned SOFT_MAX_NS      = 1000;
  localparam int unsigned HW_MIN_NS        = 1000;
  // Longest times round down
  localparam int unsigned POR_CYCLES       = (POR_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_CYCLES      = SOFT_MAX_NS / CLK_PERIOD_NS;
  // Least time rounds up
  localparam int unsigned HW_MIN_CYCLES    = (HW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES      = 3;

  // ---------------------------------------------------------------
  // Channel config field positions and defaults
  // ---------------------------------------------------------------
  localparam int unsigned CFG_STD_BIT      = 0;
  localparam int unsigned CFG_RST_BIT      = 1;
  localparam logic        STD_DEFAULT      = 1'h0;  // T1/J1
  localparam logic [1:0]  SYS_FMT_DEFAULT  = 2'h0;  // Dual-rail NRZ
  localparam logic [7:0]  IMASK_DEFAULT    = 8'hFF;
  localparam logic [7:0]  CHCFG_DEFAULT    = 8'h00;
  localparam logic [1:0]  GPIO_DIR_DEFAULT = 2'h0;  // Inputs
  localparam logic [2:0]  GLB_DEFAULT      = 3'h7;  // All global masks set

  typedef enum logic [2:0] {
    MCRC_IDLE  = 3'b001,
    MCRC_HOLD  = 3'b010,
    MCRC_COUNT = 3'b100
  } mcrc_state_e;
endpackage

// ===== design/mcrc_sync.sv
`timescale 1ns/1ps
module mcrc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      sync_out
);
  import mcrc_pkg::*;

  logic [mcrc_pkg::SYNC_STAGES-1:0] stage_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage_q  <= {mcrc_pkg::SYNC_STAGES{RESET_VAL}};
      sync_out <= RESET_VAL;
    end else begin
      stage_q <= {stage_q[mcrc_pkg::SYNC_STAGES-2:0], async_in};
      if (stage_q[2] == stage_q[1]) begin
        sync_out <= stage_q[1];
      end
    end
  end
endmodule // mcrc_sync

// ===== design/mcrc_chan.sv
`timescale 1ns/1ps
module mcrc_chan (
  input  wire logic       core_clk,
  input  wire logic       glb_rst,
  input  wire logic       ch_rst,
  input  wire logic       cfg_we,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       mask_we,
  input  wire logic [7:0] mask_wdata,
  input  wire logic       fmt_we,
  input  wire logic [1:0] fmt_wdata,
  input  wire logic       line_en_req,
  input  wire logic       hold_hz,
  output logic            standard_q,
  output logic [7:0]      imask_q,
  output logic [1:0]      sys_fmt_q,
  output logic            line_oe_q,
  output logic            ch_sm_reset_q
);
  import mcrc_pkg::*;

  // ---------------------------------------------------------------
  // Standard select: only global resets restore it
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (glb_rst) begin
      standard_q <= mcrc_pkg::STD_DEFAULT;
    end else if (cfg_we) begin
      standard_q <= cfg_wdata[mcrc_pkg::CFG_STD_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (glb_rst || ch_rst) begin
      imask_q <= mcrc_pkg::IMASK_DEFAULT;
    end else if (mask_we) begin
      imask_q <= mask_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (glb_rst || ch_rst) begin
      sys_fmt_q <= mcrc_pkg::SYS_FMT_DEFAULT;
    end else if (fmt_we) begin
      sys_fmt_q <= fmt_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (glb_rst || ch_rst || hold_hz) begin
      line_oe_q <= 1'b0;
    end else begin
      line_oe_q <= line_en_req;
    end
  end

  always_ff @(posedge core_clk) begin
    ch_sm_reset_q <= glb_rst || ch_rst;
  end
endmodule // mcrc_chan

// ===== design/mcrc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Global-class reset puts every channel's line pins in high impedance.
// - Channel reset puts only that channel's line pins in high impedance.
// - Global-class reset returns every channel standard to T1/J1.
// - System format defaults to dual-rail NRZ; channel reset affects own channel.
// - Global-class reset makes host data and GPIO pins inputs.
// - Global reset resets all state machines; channel reset only its own.
// - Channel reset returns that channel's state machines to initial state.
// - Global-class reset masks every interrupt source.
// - Channel reset masks that channel's interrupt sources only.
// - Global-class reset loads every register with its default.
// - Channel reset defaults its registers except the standard select bit.
// - Power-on reset completes within 1 ms with reference clock present.
// - Low reset pin starts hardware reset, held over 1 us by outside.
// - Any global reset register write starts reset finishing within 1 us.
// - Channel reset starts only on writing one to config bit 1.
// - Channel reset finishes within 1 us and its bit self-clears.
// - Channel reset keeps the standard select bit at bit 0.
// - Channel reset leaves global registers, common logic and pins untouched.
// - Channel reset affects no channel other than the addressed one.
// - Line pins stay high impedance while any reset affecting their channel is in progress.
// - Global-class resets also reset clock generator and host interface.
module mcrc_top #(
  parameter int unsigned NUM_CH     = 22,
  parameter int unsigned CH_W       = 5,
  parameter int unsigned POR_CYCLES = mcrc_pkg::POR_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              ref_clk_ok,
  input  wire logic              hw_rst_n,
  input  wire logic              glb_rst_wr,
  input  wire logic              cfg_wr,
  input  wire logic [CH_W-1:0]   cfg_ch,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic              mask_wr,
  input  wire logic [CH_W-1:0]   mask_ch,
  input  wire logic [7:0]        mask_wdata,
  input  wire logic              fmt_wr,
  input  wire logic [CH_W-1:0]   fmt_ch,
  input  wire logic [1:0]        fmt_wdata,
  input  wire logic [NUM_CH-1:0] line_en_req,
  input  wire logic              gpio_dir_wr,
  input  wire logic [1:0]        gpio_dir_wdata,
  input  wire logic              glb_cfg_wr,
  input  wire logic [2:0]        glb_cfg_wdata,
  output logic [NUM_CH-1:0]      tx_line_oe,
  output logic [NUM_CH-1:0]      rx_line_oe,
  output logic [NUM_CH-1:0]      channel_standard_select,
  output logic [NUM_CH-1:0]      channel_soft_reset_bit,
  output logic [NUM_CH*8-1:0]    chan_imask,
  output logic [NUM_CH*2-1:0]    chan_sys_fmt,
  output logic [NUM_CH-1:0]      chan_sm_reset,
  output logic                   data_bus_oe_en,
  output logic [1:0]             gpio_dir,
  output logic [2:0]             glb_cfg,
  output logic                   common_reset,
  output logic                   reset_active,
  output logic [mcrc_pkg::CHCFG_DEFAULT[1:0]+1:0] unused_pad
);
  import mcrc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic hw_rst_n_s;
  logic ref_ok_s;

  mcrc_sync #(.RESET_VAL(1'b0)) u_sync_rst (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (hw_rst_n),
    .sync_out (hw_rst_n_s)
  );

  mcrc_sync #(.RESET_VAL(1'b0)) u_sync_ref (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (ref_clk_ok),
    .sync_out (ref_ok_s)
  );

  // ---------------------------------------------------------------
  // Global reset sequencer
  // ---------------------------------------------------------------
  // Wide enough for either length, whichever is longer
  localparam int unsigned CNT_MAX = (POR_CYCLES > SOFT_CYCLES) ? POR_CYCLES : SOFT_CYCLES;
  localparam int unsigned CNT_W   = $clog2(CNT_MAX + 1);

  mcrc_state_e     state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             por_done_q;
  logic             glb_rst_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= MCRC_HOLD;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        MCRC_IDLE: begin
          // Losing the reference clock re-enters hold
          if (!hw_rst_n_s || !ref_ok_s) begin
            state_q <= MCRC_HOLD;
          end else if (glb_rst_wr) begin
            state_q <= MCRC_COUNT;
            cnt_q   <= CNT_W'(SOFT_CYCLES - 1);
          end
        end
        MCRC_HOLD: begin
          // Wait for reference clock and released pin
          if (ref_ok_s && hw_rst_n_s) begin
            state_q <= MCRC_COUNT;
            cnt_q   <= por_done_q ? CNT_W'(SOFT_CYCLES - 1) : CNT_W'(POR_CYCLES - 1);
          end
        end
        MCRC_COUNT: begin
          if (!hw_rst_n_s || !ref_ok_s) begin
            state_q <= MCRC_HOLD;
          end else if (cnt_q == '0) begin
            state_q <= MCRC_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= MCRC_HOLD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Global reset level
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      glb_rst_q <= 1'b1;
    end else begin
      glb_rst_q <= (state_q != MCRC_IDLE) || !hw_rst_n_s || !ref_ok_s || glb_rst_wr;
    end
  end

  // Later releases use the soft length
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      por_done_q <= 1'b0;
    end else if (state_q == MCRC_COUNT && cnt_q == '0 && hw_rst_n_s && ref_ok_s) begin
      por_done_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel reset request and completion
  // ---------------------------------------------------------------
  localparam int unsigned CH_CNT_W = $clog2(SOFT_CYCLES + 1);

  logic [NUM_CH-1:0] ch_busy_q;
  logic [NUM_CH-1:0] ch_line_oe;
  logic [NUM_CH-1:0] ch_std;
  logic [7:0]        ch_imask [NUM_CH];
  logic [1:0]        ch_fmt   [NUM_CH];
  logic [NUM_CH-1:0] ch_smr;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [CH_CNT_W-1:0] ch_cnt_q;
      logic                sel_cfg;
      logic                start;

      assign sel_cfg = cfg_wr && (cfg_ch == CH_W'(g));
      assign start   = sel_cfg && cfg_wdata[CFG_RST_BIT] && !glb_rst_q;

      // Restart while busy is ignored
      always_ff @(posedge core_clk) begin
        if (!nrst || glb_rst_q) begin
          ch_busy_q[g] <= 1'b0;
        end else if (start && !ch_busy_q[g]) begin
          ch_busy_q[g] <= 1'b1;
        end else if (ch_busy_q[g] && ch_cnt_q == '0) begin
          ch_busy_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!nrst || glb_rst_q) begin
          ch_cnt_q <= '0;
        end else if (start && !ch_busy_q[g]) begin
          ch_cnt_q <= CH_CNT_W'(SOFT_CYCLES - 1);
        end else if (ch_busy_q[g] && ch_cnt_q != '0) begin
          ch_cnt_q <= ch_cnt_q - 1'b1;
        end
      end

      // ---------------------------------------------------------------
      // Channel register bank
      // ---------------------------------------------------------------
      mcrc_chan u_chan (
        .core_clk      (core_clk),
        .glb_rst       (glb_rst_q || !nrst),
        .ch_rst        (ch_busy_q[g] || start),
        .cfg_we        (sel_cfg),
        .cfg_wdata     (cfg_wdata),
        .mask_we       (mask_wr && (mask_ch == CH_W'(g))),
        .mask_wdata    (mask_wdata),
        .fmt_we        (fmt_wr && (fmt_ch == CH_W'(g))),
        .fmt_wdata     (fmt_wdata),
        .line_en_req   (line_en_req[g]),
        .hold_hz       (start),
        .standard_q    (ch_std[g]),
        .imask_q       (ch_imask[g]),
        .sys_fmt_q     (ch_fmt[g]),
        .line_oe_q     (ch_line_oe[g]),
        .ch_sm_reset_q (ch_smr[g])
      );

      // ---------------------------------------------------------------
      // Channel output registers
      // ---------------------------------------------------------------
      always_ff @(posedge core_clk) begin
        tx_line_oe[g] <= ch_line_oe[g] && !glb_rst_q;
      end

      always_ff @(posedge core_clk) begin
        rx_line_oe[g] <= ch_line_oe[g] && !glb_rst_q;
      end

      always_ff @(posedge core_clk) begin
        channel_standard_select[g] <= ch_std[g];
      end

      always_ff @(posedge core_clk) begin
        channel_soft_reset_bit[g] <= ch_busy_q[g];
      end

      always_ff @(posedge core_clk) begin
        chan_imask[g*8 +: 8] <= ch_imask[g];
      end

      always_ff @(posedge core_clk) begin
        chan_sys_fmt[g*2 +: 2] <= ch_fmt[g];
      end

      always_ff @(posedge core_clk) begin
        chan_sm_reset[g] <= ch_smr[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Common registers and pins
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst || glb_rst_q) begin
      gpio_dir <= GPIO_DIR_DEFAULT;
    end else if (gpio_dir_wr) begin
      gpio_dir <= gpio_dir_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || glb_rst_q) begin
      glb_cfg <= GLB_DEFAULT;
    end else if (glb_cfg_wr) begin
      glb_cfg <= glb_cfg_wdata;
    end
  end

  // Host data bus stays an input here
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      data_bus_oe_en <= 1'b0;
    end else begin
      data_bus_oe_en <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      common_reset <= 1'b1;
    end else begin
      common_reset <= glb_rst_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reset_active <= 1'b1;
    end else begin
      reset_active <= glb_rst_q || (|ch_busy_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      unused_pad <= '0;
    end else begin
      unused_pad <= '0;
    end
  end
endmodule // mcrc_top

// ===== verif/mcrc_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reset controller checker
// ----------------------------------------
module mcrc_asserts #(
  parameter int unsigned NUM_CH = 22,
  parameter int unsigned CH_W   = 5
) (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              ref_clk_ok,
  input wire logic              hw_rst_n,
  input wire logic              glb_rst_wr,
  input wire logic              cfg_wr,
  input wire logic [CH_W-1:0]   cfg_ch,
  input wire logic [7:0]        cfg_wdata,
  input wire logic [NUM_CH-1:0] tx_line_oe,
  input wire logic [NUM_CH-1:0] rx_line_oe,
  input wire logic [NUM_CH-1:0] channel_standard_select,
  input wire logic [NUM_CH-1:0] channel_soft_reset_bit,
  input wire logic [NUM_CH*8-1:0] chan_imask,
  input wire logic [NUM_CH*2-1:0] chan_sys_fmt,
  input wire logic              data_bus_oe_en,
  input wire logic [1:0]        gpio_dir,
  input wire logic [2:0]        glb_cfg,
  input wire logic              common_reset,
  input wire logic              reset_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  glb_start_a: assert property (glb_rst_wr |-> ##[1:3] reset_active ##[1:105] !reset_active)
    else $error("global soft reset start or finish out of time");
  line_hiz_a: assert property (common_reset [*2] |-> tx_line_oe == '0 && rx_line_oe == '0)
    else $error("line pins driven during reset");
  glb_dflt_a: assert property (common_reset [*2] |->
    chan_imask == '1 && channel_standard_select == '0 && chan_sys_fmt == '0)
    else $error("channel defaults wrong in global reset");
  glb_common_a: assert property (common_reset [*2] |->
    common_reset && gpio_dir == 2'h0 && glb_cfg == 3'h7 && !data_bus_oe_en)
    else $error("common defaults wrong in global reset");
  ch_start_a: assert property (cfg_wr && cfg_wdata[1] && !glb_rst_wr && !reset_active
    && channel_soft_reset_bit == '0 |-> ##2 channel_soft_reset_bit[$past(cfg_ch, 2)])
    else $error("channel reset did not start");
  ch_noop_a: assert property (cfg_wr && !cfg_wdata[1] && channel_soft_reset_bit == '0
    |-> ##2 channel_soft_reset_bit == '0)
    else $error("channel reset started by a zero");
  ch_done_a: assert property ($rose(|channel_soft_reset_bit) |-> ##[1:101] channel_soft_reset_bit == '0)
    else $error("channel reset bit did not self clear");
  ch_hiz_a: assert property (channel_soft_reset_bit[0] |-> !tx_line_oe[0] && !rx_line_oe[0]
    && chan_imask[7:0] == 8'hFF && chan_sys_fmt[1:0] == 2'h0)
    else $error("channel reset effects missing");
  ch_keep_a: assert property ($rose(channel_soft_reset_bit[0]) |-> $stable(channel_standard_select)
    && $stable(chan_imask[NUM_CH*8-1:8]) && $stable(gpio_dir) && $stable(glb_cfg) && !common_reset)
    else $error("channel reset touched state it must keep");
  hw_hold_a: assert property (!hw_rst_n [*6] |=> reset_active)
    else $error("reset pin low without reset");
  ref_hold_a: assert property (!ref_clk_ok [*6] |=> reset_active)
    else $error("no reference clock without reset");

  glb_c: cover property (glb_rst_wr);
  ch_c: cover property ($rose(|channel_soft_reset_bit));
  hw_c: cover property ($fell(hw_rst_n));
endmodule // mcrc_asserts

bind mcrc_top mcrc_asserts #(.NUM_CH(NUM_CH), .CH_W(CH_W)) u_chk (.*);

// ===== verif/mcrc_board.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board reset circuit and clock monitor
// ----------------------------------------
module mcrc_board #(
  parameter int unsigned HOLD = 101
) (
  input  wire logic core_clk,
  input  wire logic hw_req,
  input  wire logic clk_on,
  output logic      hw_rst_n,
  output logic      ref_clk_ok
);
  int unsigned cnt_q = 0;
  initial hw_rst_n = 1'b1;
  initial ref_clk_ok = 1'b1;
  always @(negedge core_clk) begin
    ref_clk_ok <= clk_on;
    if (hw_req) begin
      cnt_q <= HOLD;
      hw_rst_n <= 1'b0;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end else begin
      hw_rst_n <= 1'b1;
    end
  end
endmodule // mcrc_board

// ===== verif/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Reset controller bench
// ----------------------------------------
module testbench;
  localparam int unsigned NCH = 22;
  logic core_clk, nrst, glb_rst_wr, cfg_wr, mask_wr, fmt_wr, gpio_dir_wr, glb_cfg_wr, hw_req, clk_on;
  logic ref_clk_ok, hw_rst_n, data_bus_oe_en, common_reset, reset_active;
  logic [4:0]       cfg_ch, mask_ch, fmt_ch;
  logic [7:0]       cfg_wdata, mask_wdata;
  logic [1:0]       fmt_wdata, gpio_dir_wdata, gpio_dir;
  logic [2:0]       glb_cfg_wdata, glb_cfg;
  logic [NCH-1:0]   line_en_req, tx_line_oe, rx_line_oe, channel_standard_select, channel_soft_reset_bit;
  logic [NCH-1:0]   chan_sm_reset;
  logic [NCH*8-1:0] chan_imask;
  logic [NCH*2-1:0] chan_sys_fmt;
  int               n_mismatch = 0;
  int               comparisons = 0;

  mcrc_top #(.POR_CYCLES(50)) dut (.*, .unused_pad());
  mcrc_board #(.HOLD(101)) u_board (.core_clk, .hw_req, .clk_on, .hw_rst_n, .ref_clk_ok);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [175:0] got, input logic [175:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input int k, input logic [4:0] ch, input logic [7:0] d);
    @(negedge core_clk);
    {cfg_ch, mask_ch, fmt_ch} = {3{ch}};
    {cfg_wdata, mask_wdata} = {2{d}};
    {fmt_wdata, gpio_dir_wdata, glb_cfg_wdata} = {d[1:0], d[1:0], d[2:0]};
    {cfg_wr, mask_wr, fmt_wr, gpio_dir_wr, glb_cfg_wr, glb_rst_wr} = 6'h20 >> k;
    @(negedge core_clk);
    {cfg_wr, mask_wr, fmt_wr, gpio_dir_wr, glb_cfg_wr, glb_rst_wr} = '0;
  endtask

  task automatic wait_idle(input int max);
    int n;
    n = 0;
    while (reset_active !== 1'b0 && n < max) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= max, 0);
    @(negedge core_clk);
  endtask

  task automatic chk_dflt();
    chk(channel_standard_select, 0);
    chk(chan_sys_fmt, 0);
    chk({data_bus_oe_en, gpio_dir}, 0);
    chk(chan_imask, {NCH{8'hFF}});
    chk(glb_cfg, 3'h7);
  endtask

  task automatic test_por();
    wait_idle(70);
    chk_dflt();
    chk(tx_line_oe & rx_line_oe, {NCH{1'b1}});
    $display("test_por done");
  endtask

  task automatic test_chan();
    int n;
    wr(2, 0, 8'h01);
    wr(1, 0, 8'h0F);
    wr(1, 1, 8'h5A);
    wr(4, 0, 8'h02);
    wr(3, 0, 8'h01);
    wr(0, 1, 8'h01);
    wr(0, 0, 8'h01);
    chk(channel_soft_reset_bit, 0);
    wr(0, 0, 8'h03);
    @(negedge core_clk);
    chk(channel_soft_reset_bit, 1);
    chk({tx_line_oe[1:0], rx_line_oe[1:0]}, 4'hA);
    chk({chan_imask[7:0], chan_sys_fmt[1:0]}, 10'h3FC);
    chk(chan_sm_reset[1], 0);
    n = 0;
    while (channel_soft_reset_bit[0] !== 1'b0 && n < 110) begin
      @(negedge core_clk);
      n++;
    end
    chk(n > 100, 0);
    chk(channel_standard_select[1:0], 2'h3);
    chk(chan_imask[15:8], 8'h5A);
    chk({gpio_dir, glb_cfg, common_reset}, {2'h1, 3'h2, 1'b0});
    $display("test_chan done");
  endtask

  task automatic test_glb();
    wr(5, 0, 8'hA5);
    repeat (2) @(negedge core_clk);
    chk(reset_active, 1);
    wr(0, 2, 8'h02);
    chk({tx_line_oe, rx_line_oe, channel_soft_reset_bit}, 0);
    chk(common_reset, 1);
    wait_idle(105);
    chk_dflt();
    $display("test_glb done");
  endtask

  task automatic test_hw();
    hw_req <= 1'b1;
    repeat (10) @(negedge core_clk);
    chk({reset_active, tx_line_oe}, {1'b1, {NCH{1'b0}}});
    hw_req <= 1'b0;
    wait_idle(250);
    chk_dflt();
    $display("test_hw done");
  endtask

  task automatic test_ref();
    clk_on <= 1'b0;
    repeat (150) @(negedge core_clk);
    chk(reset_active, 1);
    clk_on <= 1'b1;
    wait_idle(120);
    $display("test_ref done");
  endtask

  task automatic test_done();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(20000 * 10);
    n_mismatch++;
    test_done();
  end

  initial begin
    {nrst, glb_rst_wr, cfg_wr, mask_wr, fmt_wr, gpio_dir_wr, glb_cfg_wr, hw_req} = '0;
    {cfg_ch, mask_ch, fmt_ch, cfg_wdata, mask_wdata} = '0;
    {fmt_wdata, gpio_dir_wdata, glb_cfg_wdata} = '0;
    clk_on = 1'b1;
    line_en_req = '1;
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    test_por();
    test_chan();
    test_glb();
    test_hw();
    test_ref();
    test_done();
  end
endmodule // testbench
